// *** hdl/stfc_defines.vh ***
/*
 * Register map, field positions, reset values and timing counts for the
 * serial transmit and frame-format block.
 * Assumes inclusion by bare name from design files under hdl/.
 */
// What this block does
// [RULE_01] Move holding byte into shifter when shifter empty, then start sending.
// [RULE_02] Holding register accepts a new byte while shifter sends; no gap.
// [RULE_03] Holding register is 8 bits, readable and writable at any time.
// [RULE_04] Holding register becomes all ones on reset and low-power entry.
// [RULE_05] Format register read/write any time; zero on reset and low-power entry.
// [RULE_06] Format bit 7 selects async (0) or clocked sync (1).
// [RULE_07] Char-length bit: async 8 bits (0) or 7 bits (1); sync always 8.
// [RULE_08] In 7-bit async mode the holding MSB is not sent.
// [RULE_09] Parity enable adds parity in async only; never in sync mode.
// [RULE_10] Parity sense picks even (0) or odd (1); ignored if unused.
// [RULE_11] Parity makes count of ones in data plus parity even or odd.
// [RULE_12] Async stop bits: one when clear, two when set; none in sync.
// [RULE_13] Receiver checks only the first stop bit; second zero is a start.
// [RULE_14] Multiprocessor mode overrides parity settings; software clears it in sync.
// [RULE_15] Prescaler select: 00 full, 01 quarter, 10 sixteenth, 11 sixty-fourth.
// [RULE_16] Control register holds enables, interrupt enables and clock source bits.
// [RULE_17] Control register read/write any time; zero on reset and low-power entry.
// [RULE_18] Shifter sends each character least significant bit first.
// [RULE_19] No holding-to-shifter transfer while the empty flag is set.
// [RULE_20] Async character: one zero start bit, data, optional parity, stop bits.
`ifndef STFC_DEFINES_VH
`define STFC_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define STFC_ADDR_FORMAT 3'h0
`define STFC_ADDR_BITRATE 3'h1
`define STFC_ADDR_CONTROL 3'h2
`define STFC_ADDR_HOLDING 3'h3
`define STFC_ADDR_STATUS 3'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define STFC_RST_HOLDING 8'hff
`define STFC_RST_FORMAT 8'h00
`define STFC_RST_CONTROL 8'h00
`define STFC_RST_BITRATE 8'hff

// ----------------------------------------------------------------------
// Format register fields
// ----------------------------------------------------------------------
`define STFC_FMT_SYNC 7
`define STFC_FMT_CHR7 6
`define STFC_FMT_PAR_ON 5
`define STFC_FMT_PAR_ODD 4
`define STFC_FMT_STOP2 3
`define STFC_FMT_MP 2
`define STFC_FMT_PSC_HI 1
`define STFC_FMT_PSC_LO 0

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define STFC_CTL_TX_ON 5

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STFC_STS_TX_EMPTY 7
`define STFC_STS_TX_END 2
`define STFC_STS_MPB_TX 0

// ----------------------------------------------------------------------
// Prescaler terminal counts (divide minus one)
// ----------------------------------------------------------------------
`define STFC_PSC_DIV1 6'h00
`define STFC_PSC_DIV4 6'h03
`define STFC_PSC_DIV16 6'h0f
`define STFC_PSC_DIV64 6'h3f

`endif

// *** hdl/stfc_top.v ***
/*
 * Transmit holding path and frame-format control of a serial port:
 * format, control, bit-rate and holding registers, a byte shifter that
 * frames async or clocked sync characters, and a prescaled bit clock.
 * Assumes a simple synchronous register port driven by one master, and
 * a low-power indication from the system that is high for the cycles of
 * entry into standby, watch, subactive or subsleep mode.
 */
`timescale 1ns/1ps
`include "stfc_defines.vh"

module stfc_top #(
    parameter DATA_W = 8 // Character register width
) (
    input wire ref_clk_in,              // System clock, 25 MHz
    input wire rstn_in,                 // Async reset, active low
    input wire clk_en_in,               // Freezes all state but the reset synchroniser when low
    input wire low_power_in,            // Low-power mode entry, level
    input wire [2:0] addr_in,           // Register address
    input wire [7:0] wdata_in,          // Register write data
    input wire wr_in,                   // Write strobe
    input wire rd_in,                   // Read strobe
    output reg [7:0] rdata_out,         // Read data, cycle after strobe
    output reg txd_out,                 // Serial transmit data
    output reg sck_out,                 // Serial clock out (sync mode)
    output reg sck_oe_out,              // Serial clock output enable
    output wire tx_empty_flag_out,      // Holding register empty
    output wire tx_end_out,             // Shifter idle and holding empty
    output wire [7:0] serial_control_out // Control bits for other blocks
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    // Release is delayed two edges so no flop leaves reset on a ragged edge
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // ------------------------------------------------------------------
    // State machine codes
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_DATA = 4'b0100;
    localparam [3:0] ST_TAIL = 4'b1000;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    reg [DATA_W-1:0] tx_holding_reg;
    reg [7:0] frame_format_reg;
    reg [7:0] serial_control_reg;
    reg [7:0] bitrate_reg;
    reg tx_empty_reg;
    reg mpb_tx_reg;
    reg [DATA_W-1:0] tx_shifter_reg;
    reg [3:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [1:0] tail_cnt_reg;
    reg shift_par_reg;
    reg shift_mp_reg;
    reg [5:0] psc_cnt_reg;
    reg [7:0] baud_cnt_reg;
    reg half_reg;

    // Frame settings latched at load so a mid-frame write cannot tear it
    reg fr_sync_reg;
    reg fr_chr7_reg;
    reg fr_par_reg;
    reg fr_stop2_reg;
    reg fr_mp_reg;

    wire fmt_sync = frame_format_reg[`STFC_FMT_SYNC];
    wire tx_on = serial_control_reg[`STFC_CTL_TX_ON];

    // Prescaler terminal decode, used only for the bit clock
    function [5:0] psc_limit;
        input [1:0] sel;
        begin
            case (sel) // RULE_15
                2'b00: psc_limit = `STFC_PSC_DIV1;
                2'b01: psc_limit = `STFC_PSC_DIV4;
                2'b10: psc_limit = `STFC_PSC_DIV16;
                default: psc_limit = `STFC_PSC_DIV64;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Bit clock: prescaler then bit-rate counter, half-bit ticks
    // ------------------------------------------------------------------
    wire [5:0] psc_top = psc_limit({frame_format_reg[`STFC_FMT_PSC_HI],
                                    frame_format_reg[`STFC_FMT_PSC_LO]});
    wire psc_tick = (psc_cnt_reg == psc_top);
    wire half_tick = psc_tick && (baud_cnt_reg == 8'h00);
    // Each bit lasts two half ticks so sync mode gets a symmetric clock
    wire bit_tick = half_tick && half_reg;

    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            psc_cnt_reg <= 6'h00;
            baud_cnt_reg <= 8'h00;
            half_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (state_reg == ST_IDLE) begin
                // Restart the bit clock so each frame starts on a full bit
                psc_cnt_reg <= 6'h00;
                baud_cnt_reg <= bitrate_reg;
                half_reg <= 1'b0;
            end else if (psc_tick) begin
                psc_cnt_reg <= 6'h00; // RULE_15
                if (baud_cnt_reg == 8'h00) begin
                    baud_cnt_reg <= bitrate_reg;
                    half_reg <= ~half_reg;
                end else begin
                    baud_cnt_reg <= baud_cnt_reg - 8'h01;
                end
            end else begin
                psc_cnt_reg <= psc_cnt_reg + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes and the empty flag
    // ------------------------------------------------------------------
    wire wr_hold = wr_in && (addr_in == `STFC_ADDR_HOLDING);
    wire load = (state_reg == ST_IDLE) && tx_on && !tx_empty_reg; // RULE_01 RULE_19
    wire frame_done;

    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_holding_reg <= `STFC_RST_HOLDING; // RULE_04
            frame_format_reg <= `STFC_RST_FORMAT; // RULE_05
            serial_control_reg <= `STFC_RST_CONTROL; // RULE_17
            bitrate_reg <= `STFC_RST_BITRATE;
            tx_empty_reg <= 1'b1;
            mpb_tx_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (low_power_in) begin
                tx_holding_reg <= `STFC_RST_HOLDING; // RULE_04
                frame_format_reg <= `STFC_RST_FORMAT; // RULE_05
                serial_control_reg <= `STFC_RST_CONTROL; // RULE_17
                bitrate_reg <= `STFC_RST_BITRATE;
                tx_empty_reg <= 1'b1;
                mpb_tx_reg <= 1'b0;
            end else begin
                if (wr_in && addr_in == `STFC_ADDR_FORMAT)
                    frame_format_reg <= wdata_in; // RULE_05
                if (wr_in && addr_in == `STFC_ADDR_BITRATE)
                    bitrate_reg <= wdata_in;
                if (wr_in && addr_in == `STFC_ADDR_CONTROL)
                    serial_control_reg <= wdata_in; // RULE_16 RULE_17
                if (wr_in && addr_in == `STFC_ADDR_STATUS)
                    mpb_tx_reg <= wdata_in[`STFC_STS_MPB_TX];
                // Holding register is writable even mid-frame
                if (wr_hold)
                    tx_holding_reg <= wdata_in[DATA_W-1:0]; // RULE_02 RULE_03
                // Empty stays set while transmit is off; a write wins
                // over the load in the same cycle
                if (!tx_on)
                    tx_empty_reg <= 1'b1;
                else if (wr_hold)
                    tx_empty_reg <= 1'b0; // RULE_02
                else if (load)
                    tx_empty_reg <= 1'b1; // RULE_01
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------------
    // Par_used is false in sync or multiprocessor mode
    wire par_used = !fmt_sync && frame_format_reg[`STFC_FMT_PAR_ON] &&
                    !frame_format_reg[`STFC_FMT_MP]; // RULE_09 RULE_14
    wire chr7 = !fmt_sync && frame_format_reg[`STFC_FMT_CHR7]; // RULE_07
    wire [DATA_W-1:0] load_data = chr7 ?
        {1'b0, tx_holding_reg[DATA_W-2:0]} : tx_holding_reg; // RULE_08
    // Parity over the bits actually sent; odd sense inverts
    wire load_par = (^load_data) ^ frame_format_reg[`STFC_FMT_PAR_ODD]; // RULE_10 RULE_11
    wire [3:0] last_bit = fr_chr7_reg ? 4'h6 : 4'h7;
    wire [1:0] tail_len = {1'b0, fr_par_reg} + {1'b0, fr_mp_reg} +
                          (fr_stop2_reg ? 2'h2 : 2'h1); // RULE_12
    assign frame_done = (state_reg == ST_TAIL) && bit_tick &&
                        (tail_cnt_reg == tail_len - 2'h1);

    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            tx_shifter_reg <= {DATA_W{1'b1}};
            bit_cnt_reg <= 4'h0;
            tail_cnt_reg <= 2'h0;
            shift_par_reg <= 1'b0;
            shift_mp_reg <= 1'b0;
            fr_sync_reg <= 1'b0;
            fr_chr7_reg <= 1'b0;
            fr_par_reg <= 1'b0;
            fr_stop2_reg <= 1'b0;
            fr_mp_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (low_power_in) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (load) begin
                            tx_shifter_reg <= load_data; // RULE_01
                            shift_par_reg <= load_par;
                            shift_mp_reg <= mpb_tx_reg;
                            fr_sync_reg <= fmt_sync; // RULE_06
                            fr_chr7_reg <= chr7;
                            fr_par_reg <= par_used;
                            fr_stop2_reg <= frame_format_reg[`STFC_FMT_STOP2];
                            fr_mp_reg <= !fmt_sync && frame_format_reg[`STFC_FMT_MP];
                            bit_cnt_reg <= 4'h0;
                            tail_cnt_reg <= 2'h0;
                            // Sync mode has no start bit
                            state_reg <= fmt_sync ? ST_DATA : ST_START; // RULE_06 RULE_20
                        end
                    end
                    ST_START: begin
                        if (bit_tick)
                            state_reg <= ST_DATA; // RULE_20
                    end
                    ST_DATA: begin
                        if (bit_tick) begin
                            tx_shifter_reg <= {1'b1, tx_shifter_reg[DATA_W-1:1]}; // RULE_18
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == last_bit) begin
                                // Sync frames end after data: no parity, no stop
                                state_reg <= fr_sync_reg ? ST_IDLE : ST_TAIL; // RULE_12
                            end
                        end
                    end
                    ST_TAIL: begin
                        if (bit_tick) begin
                            tail_cnt_reg <= tail_cnt_reg + 2'h1;
                            if (frame_done)
                                state_reg <= ST_IDLE; // RULE_02
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Line drivers
    // ------------------------------------------------------------------
    // Tail slot order: parity or multiprocessor bit first, then stop ones
    reg txd_next;
    always @* begin
        txd_next = 1'b1;
        case (state_reg)
            ST_START: txd_next = 1'b0; // RULE_20
            ST_DATA: txd_next = tx_shifter_reg[0]; // RULE_18
            ST_TAIL: begin
                if (tail_cnt_reg == 2'h0 && fr_par_reg)
                    txd_next = shift_par_reg; // RULE_09
                else if (tail_cnt_reg == 2'h0 && fr_mp_reg)
                    txd_next = shift_mp_reg; // RULE_14
                else
                    txd_next = 1'b1; // RULE_12
            end
            default: txd_next = 1'b1;
        endcase
    end

    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            txd_out <= 1'b1;
            sck_out <= 1'b1;
            sck_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            txd_out <= txd_next;
            // Sync clock low in first half of each data bit, idles high
            sck_out <= !(fr_sync_reg && state_reg == ST_DATA && !half_reg);
            sck_oe_out <= fmt_sync && tx_on;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    wire tx_end = (state_reg == ST_IDLE) && tx_empty_reg;
    reg [7:0] rdata_next;
    always @* begin
        rdata_next = 8'h00;
        case (addr_in)
            `STFC_ADDR_FORMAT: rdata_next = frame_format_reg; // RULE_05
            `STFC_ADDR_BITRATE: rdata_next = bitrate_reg;
            `STFC_ADDR_CONTROL: rdata_next = serial_control_reg; // RULE_17
            `STFC_ADDR_HOLDING: rdata_next = tx_holding_reg; // RULE_03
            `STFC_ADDR_STATUS: begin
                rdata_next[`STFC_STS_TX_EMPTY] = tx_empty_reg;
                rdata_next[`STFC_STS_TX_END] = tx_end;
                rdata_next[`STFC_STS_MPB_TX] = mpb_tx_reg;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data held only for the cycle after the strobe
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n)
            rdata_out <= 8'h00;
        else if (clk_en_in)
            rdata_out <= rd_in ? rdata_next : 8'h00;
    end

    assign tx_empty_flag_out = tx_empty_reg;
    assign tx_end_out = tx_end;
    assign serial_control_out = serial_control_reg;

endmodule // stfc_top

// *** tb/stfc_checker.sv ***
/* Port-level checks of the serial transmit block.
   Assumes one clock domain and a bind onto stfc_top. */
`timescale 1ns/1ps
module stfc_checker (
    input wire ref_clk_in, // System clock
    input wire rstn_in, // Reset, active low
    input wire clk_en_in, // Clock enable
    input wire low_power_in, // Low-power entry
    input wire [2:0] addr_in, // Register address
    input wire [7:0] wdata_in, // Write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    input wire [7:0] rdata_out, // Read data
    input wire txd_out, // Serial data
    input wire sck_out, // Serial clock
    input wire sck_oe_out, // Serial clock enable
    input wire tx_empty_flag_out, // Holding empty
    input wire tx_end_out, // Transmitter idle
    input wire [7:0] serial_control_out // Control bits
);
    // ----
    // Bus and frame sequences
    // ----
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_hold_wr;
        wr_in && addr_in == 3'h3 && clk_en_in && !low_power_in;
    endsequence
    sequence s_hold_rd;
        rd_in && !wr_in && addr_in == 3'h3 && clk_en_in && !low_power_in;
    endsequence
    sequence s_lp;
        low_power_in && clk_en_in;
    endsequence
    // Load seen as the empty flag rising while transmit stays enabled in async
    sequence s_load;
        !tx_empty_flag_out && serial_control_out[5] && !sck_oe_out && clk_en_in
        ##1 tx_empty_flag_out && serial_control_out[5];
    endsequence
    // ----
    // Assertions
    // ----
    AST_RD_QUIET: assert property (clk_en_in && !rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    AST_HOLD_RW: assert property (s_hold_wr ##1 (!(wr_in && addr_in == 3'h3) &&
        !low_power_in && clk_en_in) ##1 s_hold_rd |=> rdata_out == $past(wdata_in, 3))
        else $error("holding read differs from write");
    AST_HOLD_LP: assert property (s_lp ##1 s_hold_rd |=> rdata_out == 8'hff)
        else $error("holding not all ones after low power");
    AST_CTL_LP: assert property (s_lp |=> serial_control_out == 8'h00)
        else $error("control not cleared by low power");
    AST_START_BIT: assert property (s_load |=> !txd_out)
        else $error("no start bit after load");
    AST_TXD_IDLE: assert property ((tx_end_out && !sck_oe_out) [*2] |-> txd_out)
        else $error("line not high while idle");
    AST_SCK_IDLE: assert property (!sck_oe_out [*2] |-> sck_out)
        else $error("serial clock moves in async mode");
    AST_NO_LOAD: assert property (tx_end_out && clk_en_in &&
        !(wr_in && addr_in == 3'h3) |=> tx_end_out)
        else $error("transfer started with empty holding");
endmodule // stfc_checker

bind stfc_top stfc_checker u_chk (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .low_power_in(low_power_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .txd_out(txd_out),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out), .tx_empty_flag_out(tx_empty_flag_out),
    .tx_end_out(tx_end_out), .serial_control_out(serial_control_out));

// *** tb/stfc_line_rx.sv ***
/* Line-side receiver model catching async characters.
   Assumes bit length and bit count are set before each start bit. */
`timescale 1ns/1ps
module stfc_line_rx (
    input wire ref_clk_in, // System clock
    input wire line_in, // Serial line
    input wire [7:0] bit_cyc_in, // Clock cycles per bit
    input wire [3:0] nbits_in, // Bits per frame, start included
    output reg [11:0] frame_out, // Last frame, first bit at 0
    output reg [7:0] count_out // Frames caught
);
    reg [11:0] frame_reg;
    reg prev_reg;
    integer i;
    // ----
    // Sampling on falling edges keeps clear of the line's update edge
    // ----
    initial begin
        frame_out = 12'hfff;
        count_out = 8'h00;
        prev_reg = 1'b1;
        forever begin
            @(negedge ref_clk_in);
            if (prev_reg && !line_in) begin
                frame_reg = 12'hfff;
                repeat (bit_cyc_in / 2 - 1) @(negedge ref_clk_in);
                for (i = 0; i < nbits_in; i = i + 1) begin
                    if (i > 0) repeat (bit_cyc_in) @(negedge ref_clk_in);
                    frame_reg[i] = line_in;
                end
                frame_out = frame_reg;
                count_out = count_out + 8'h01;
            end
            prev_reg = line_in;
        end
    end
endmodule // stfc_line_rx

// *** tb/testbench.sv ***
/* Self-checking bench: registers, async formats, back-to-back, low power, sync.
   Assumes stfc_top, stfc_line_rx and the bound checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    reg clk, rstn, clk_en, lp, wr, rd, sck_prev;
    reg [2:0] addr;
    reg [7:0] wdata, bit_cyc, got;
    reg [3:0] nbits;
    wire [7:0] rdata, ctl, rx_count;
    wire txd, sck, sck_oe, empty, tx_end;
    wire [11:0] rx_frame;
    logic [11:0] exp_v;
    logic [7:0] row_fmt [9] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h34, 8'h01, 8'h02, 8'h03};
    logic [7:0] row_dat [9] = '{8'ha5, 8'hd3, 8'h07, 8'h07, 8'h3c, 8'h07, 8'h55, 8'h55, 8'h55};
    int err_total = 0;
    int tests_run = 0;
    int cyc_count = 0;
    int n, i, k;
    stfc_top u_dut (.ref_clk_in(clk), .rstn_in(rstn), .clk_en_in(clk_en),
        .low_power_in(lp), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .txd_out(txd), .sck_out(sck), .sck_oe_out(sck_oe),
        .tx_empty_flag_out(empty), .tx_end_out(tx_end), .serial_control_out(ctl));
    stfc_line_rx u_rx (.ref_clk_in(clk), .line_in(txd), .bit_cyc_in(bit_cyc),
        .nbits_in(nbits), .frame_out(rx_frame), .count_out(rx_count));
    // ----
    // Clock, watchdog and helpers
    // ----
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Longest row is about 1300 cycles, so this ceiling only catches a hang
    always @(posedge clk) begin
        cyc_count++;
        if (cyc_count == 10000) begin
            err_total++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask
    // Expected line bits: start, data LSB first, parity or address bit, stops
    function automatic logic [11:0] exp_frame(input logic [7:0] f, input logic [7:0] d,
        output int cnt);
        logic p;
        int j;
        exp_frame = 12'hffe;
        cnt = 1;
        p = f[4];
        for (j = 0; j < (f[6] ? 7 : 8); j++) begin
            exp_frame[cnt] = d[j];
            p = p ^ d[j];
            cnt++;
        end
        if (f[2]) exp_frame[cnt++] = 1'b1;
        else if (f[5]) exp_frame[cnt++] = p;
        cnt = cnt + (f[3] ? 2 : 1);
    endfunction
    task automatic get_frame(input logic [11:0] e);
        logic [7:0] c0;
        int t;
        c0 = rx_count;
        for (t = 0; t < 3000 && rx_count === c0; t++) @(posedge clk);
        `CHK(rx_count, c0 + 8'h01)
        `CHK(rx_frame, e)
    endtask
    task automatic send_row(input logic [7:0] f, input logic [7:0] d);
        bit_cyc = 8'd2 << (2 * f[1:0]);
        exp_v = exp_frame(f, d, n);
        nbits = n[3:0];
        wr_reg(3'h0, f);
        wr_reg(3'h3, d);
        rd_chk(3'h3, d);
        get_frame(exp_v);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        lp = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        bit_cyc = 8'd2;
        nbits = 4'd10;
        sck_prev = 1'b1;
        do_reset;
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h2, 8'h20);
        wr_reg(3'h4, 8'h01);
        for (i = 0; i < 9; i++) begin
            send_row(row_fmt[i], row_dat[i]);
            rd_chk(3'h0, row_fmt[i]);
        end
        // Second reset in mid-run, then an unmapped place
        do_reset;
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h3, 8'hff);
        `CHK(empty, 1'b1)
        wr_reg(3'h5, 8'h77);
        rd_chk(3'h5, 8'h00);
        // Two stop bits with the second byte written while the first is sent
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h2, 8'h20);
        bit_cyc = 8'd2;
        exp_v = exp_frame(8'h08, 8'h81, n);
        nbits = n[3:0];
        wr_reg(3'h0, 8'h08);
        wr_reg(3'h3, 8'h81);
        wr_reg(3'h3, 8'h7e);
        rd_chk(3'h3, 8'h7e);
        get_frame(exp_v);
        exp_v = exp_frame(8'h08, 8'h7e, n);
        get_frame(exp_v);
        repeat (6) @(posedge clk);
        `CHK(tx_end, 1'b1)
        // Low-power entry wins over a write in the same cycle
        wr_reg(3'h2, 8'hdf);
        wr_reg(3'h0, 8'h7c);
        wr_reg(3'h3, 8'h12);
        @(posedge clk);
        lp <= 1'b1;
        addr <= 3'h2;
        wdata <= 8'h20;
        wr <= 1'b1;
        @(posedge clk);
        lp <= 1'b0;
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= 3'h3;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, 8'hff)
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h2, 8'h00);
        // Sync mode, multiprocessor bit kept clear; parity and stop bits ignored
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h0, 8'hb8);
        wr_reg(3'h2, 8'h20);
        wr_reg(3'h3, 8'h96);
        k = 0;
        got = 8'h00;
        repeat (40) begin
            @(negedge clk);
            if (sck_prev === 1'b0 && sck === 1'b1) begin
                got = {txd, got[7:1]};
                k++;
            end
            sck_prev = sck;
        end
        `CHK(got, 8'h96)
        `CHK(k, 8)
        `CHK(sck_oe, 1'b1)
        tally_and_finish;
    end
endmodule // testbench
